//--- hdl/txdma_consts.svh
`ifndef TXDMA_CONSTS_SVH
`define TXDMA_CONSTS_SVH
`define TXD_NUM_CHAN 672
`define TXD_NUM_LIST 1344
`define TXD_LAST_CHAN 10'h29f
`define TXD_REG_READY 8'h00
`define TXD_REG_PROV 8'h04
`define TXD_REG_STATUS 8'h08
`define TXD_REG_LINKS 8'h0c
`define TXD_REF_PTR_LSB 0
`define TXD_REF_PRI_BIT 15
`define TXD_REF_CHAN_LSB 16
`define TXD_PROV_ACT_BIT 0
`define TXD_SEL_ALL 4'hf
`define TXD_DWORD_BYTES 16'h0004
`define TXD_ADDR_STEP 32'h0000_0004
`endif

//--- hdl/txdma_pkg.sv
package txdma_pkg;
  typedef struct packed {
    logic null_abort_pending;
    logic abrt;
    logic irq_on_complete_copy;
    logic m;
    logic ce;
    logic act;
    logic nonempty;
    logic [14:0] cur_ptr;
    logic [15:0] bytes;
    logic [14:0] host_ptr;
    logic [31:0] addr;
    logic u;
    logic packet_in_progress;
    logic [14:0] last_ptr;
    logic v;
    logic [14:0] next_ptr;
  } entry_t;
  typedef struct packed {
    logic [9:0] chan;
    logic exp;
    logic underflow;
  } req_t;
  typedef struct packed {
    logic [9:0] chan;
    logic pri;
    logic none;
    logic null_abort;
    logic last;
    logic [31:0] addr;
  } ans_t;
  typedef struct packed {
    logic [9:0] chan;
    logic pri;
    logic malformed;
    logic abrt;
    logic irq_on_complete_copy;
    logic m;
    logic ce;
    logic [15:0] bytes;
    logic [14:0] host_ptr;
    logic [31:0] addr;
  } desc_t;
  typedef struct packed {
    logic [9:0] chan;
    logic pri;
    logic [14:0] ptr;
  } ref_t;
  typedef enum logic [2:0] {
    T_NONE, T_EXP, T_LINK, T_NRM, T_DESC, T_PROV
  } task_t;
  typedef enum logic [1:0] {
    S_INIT = 2'b00, S_IDLE = 2'b01, S_READ = 2'b11, S_EXEC = 2'b10
  } state_t;
endpackage

//--- hdl/desc_table.sv
`timescale 1ns/1ps
`include "txdma_consts.svh"
module desc_table (
  input wire logic clk_sys, // clock
  input wire logic [9:0] rd_chan, // channel read
  output txdma_pkg::entry_t rd_hi, // high entry, one cycle later
  output txdma_pkg::entry_t rd_lo, // low entry, one cycle later
  input wire logic wr_hi_en, // write high entry
  input wire logic wr_lo_en, // write low entry
  input wire logic [9:0] wr_chan, // channel written
  input txdma_pkg::entry_t wr_hi, // high entry data
  input txdma_pkg::entry_t wr_lo // low entry data
);
  txdma_pkg::entry_t hi_mem [0:`TXD_NUM_CHAN-1];
  txdma_pkg::entry_t lo_mem [0:`TXD_NUM_CHAN-1];

  always_ff @(posedge clk_sys)
  begin
    if (wr_hi_en)
    begin
      hi_mem[wr_chan] <= wr_hi;
    end
    if (wr_lo_en)
    begin
      lo_mem[wr_chan] <= wr_lo;
    end
    rd_hi <= hi_mem[rd_chan];
    rd_lo <= lo_mem[rd_chan];
  end
endmodule

//--- hdl/task_arb.sv
`timescale 1ns/1ps
module task_arb (
  input wire logic exp_req, // expedited data request
  input wire logic link_req, // ready reference waiting
  input wire logic nrm_req, // ordinary data request
  input wire logic desc_req, // descriptor load waiting
  input wire logic prov_req, // provisioning change waiting
  output txdma_pkg::task_t pick // task granted
);
  always_comb
  begin
    if (exp_req)
    begin
      pick = txdma_pkg::T_EXP; // RULE17
    end
    else if (link_req)
    begin
      pick = txdma_pkg::T_LINK; // RULE18
    end
    else if (nrm_req)
    begin
      pick = txdma_pkg::T_NRM; // RULE19
    end
    else if (desc_req)
    begin
      pick = txdma_pkg::T_DESC;
    end
    else if (prov_req)
    begin
      pick = txdma_pkg::T_PROV;
    end
    else
    begin
      pick = txdma_pkg::T_NONE;
    end
  end
endmodule

//--- hdl/tx_dma_list_manager.sv
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`include "txdma_consts.svh"
// Contract
// RULE1: malformed descriptor sets null abort; sent next
// RULE2: entry keeps abort, ioc, flag, chain-end copies
// RULE3: channel active flag, one when provisioned
// RULE4: nonempty flag validates current descriptor pointer
// RULE5: fifteen-bit current descriptor pointer per entry
// RULE6: sixteen-bit byte count, decremented per access
// RULE7: fifteen-bit host next pointer from descriptor
// RULE8: 32-bit dma address, incremented per access
// RULE9: underflow sets flag; free write clears it
// RULE10: packet in progress per channel and priority
// RULE11: multi-chain flag validates next/last chain pointers
// RULE12: store last-chain and next-chain head pointers
// RULE13: posted reference linked after last chain head
// RULE14: host links inside chain; device between chains
// RULE15: 1344 lists: high and low per channel
// RULE16: new packet from high list unless empty
// RULE17: expedited requests served first
// RULE18: ready queue linking served second
// RULE19: ordinary requests served last; the arbiter puts them third, before descriptor and provisioning work
// RULE20: two table entries per channel
// RULE21: zero count advances descriptor; empty clears nonempty
module tx_dma_list_manager (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  output logic wb_ack_o, // wishbone ack
  output logic [31:0] wb_dat_o, // wishbone read data
  input wire logic req_valid, // downstream data request
  input txdma_pkg::req_t req_in, // request channel and kind
  output logic req_ready, // request slot free
  input wire logic desc_valid, // fetched descriptor fields
  input txdma_pkg::desc_t desc_in, // descriptor contents
  output logic desc_ready, // descriptor slot free
  output logic ans_valid, // answer pulse
  output txdma_pkg::ans_t ans_out, // answer to request
  output logic free_valid, // reference released pulse
  output txdma_pkg::ref_t free_ref, // released reference
  output logic free_uflow, // underflow status of it
  output logic link_valid, // chain link pulse
  output logic [14:0] link_from, // head of previous last chain
  output txdma_pkg::ref_t link_to, // newly linked chain
  output logic fetch_valid, // descriptor fetch pulse
  output txdma_pkg::ref_t fetch_ref // descriptor to fetch
);
  typedef struct packed {
    txdma_pkg::state_t st;
    txdma_pkg::task_t tk;
    logic [9:0] cnt;
    logic [9:0] chan;
    logic req_v;
    txdma_pkg::req_t req;
    logic ref_v;
    txdma_pkg::ref_t rref;
    logic desc_v;
    txdma_pkg::desc_t desc;
    logic prov_v;
    logic [9:0] prov_chan;
    logic prov_act;
    logic req_rdy;
    logic desc_rdy;
    logic ack;
    logic [31:0] rdat;
    logic ans_v;
    txdma_pkg::ans_t ans;
    logic free_v;
    txdma_pkg::ref_t free;
    logic free_u;
    logic link_v;
    logic [14:0] link_from;
    txdma_pkg::ref_t link_to;
    logic fetch_v;
    txdma_pkg::ref_t fetch;
    logic [15:0] links;
  } core_t;

  logic [1:0] rst_q;
  logic rst_n;
  core_t s_q;
  core_t s_d;
  txdma_pkg::entry_t hi;
  txdma_pkg::entry_t lo;
  txdma_pkg::entry_t e;
  txdma_pkg::entry_t hi_w;
  txdma_pkg::entry_t lo_w;
  logic wr_hi_en;
  logic wr_lo_en;
  logic p;
  txdma_pkg::task_t pick;

  function automatic logic [15:0] dec_bytes(input logic [15:0] b);
    dec_bytes = (b > `TXD_DWORD_BYTES) ? b - `TXD_DWORD_BYTES : 16'h0000;
  endfunction

  // step to the next descriptor once a buffer is done
  function automatic txdma_pkg::entry_t advance(
    input txdma_pkg::entry_t x);
    advance = x;
    advance.u = 1'b0; // RULE9
    advance.bytes = 16'h0000;
    if (!x.ce)
    begin
      advance.cur_ptr = x.host_ptr; // RULE21
    end
    else if (x.v)
    begin
      advance.cur_ptr = x.next_ptr; // RULE21
      advance.v = (x.next_ptr != x.last_ptr); // RULE11
    end
    else
    begin
      advance.nonempty = 1'b0; // RULE21
    end
  endfunction

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_q <= 2'b00;
    end
    else
    begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  task_arb u_arb ( // RULE17 RULE18 RULE19
    .exp_req(s_q.req_v && s_q.req.exp),
    .link_req(s_q.ref_v),
    .nrm_req(s_q.req_v && !s_q.req.exp),
    .desc_req(s_q.desc_v),
    .prov_req(s_q.prov_v),
    .pick(pick)
  );

  desc_table u_table ( // RULE15 RULE20
    .clk_sys(clk_sys),
    .rd_chan(s_q.chan),
    .rd_hi(hi),
    .rd_lo(lo),
    .wr_hi_en(wr_hi_en),
    .wr_lo_en(wr_lo_en),
    .wr_chan(s_q.st == txdma_pkg::S_INIT ? s_q.cnt : s_q.chan),
    .wr_hi(hi_w),
    .wr_lo(lo_w)
  );

  always_comb
  begin
    s_d = s_q;
    hi_w = hi;
    lo_w = lo;
    wr_hi_en = 1'b0;
    wr_lo_en = 1'b0;
    p = 1'b0;
    e = lo;
    s_d.ans_v = 1'b0;
    s_d.free_v = 1'b0;
    s_d.link_v = 1'b0;
    s_d.fetch_v = 1'b0;
    // register bus, single answer per request
    s_d.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !s_q.ack)
    begin
      s_d.rdat = 32'h0000_0000;
      if (wb_we_i && wb_adr_i == `TXD_REG_READY)
      begin
        s_d.ack = !s_q.ref_v;
        if (!s_q.ref_v && wb_sel_i == `TXD_SEL_ALL)
        begin
          s_d.ref_v = 1'b1;
          s_d.rref.ptr = wb_dat_i[`TXD_REF_PTR_LSB +: 15];
          s_d.rref.pri = wb_dat_i[`TXD_REF_PRI_BIT];
          s_d.rref.chan = wb_dat_i[`TXD_REF_CHAN_LSB +: 10];
        end
      end
      else if (wb_we_i && wb_adr_i == `TXD_REG_PROV)
      begin
        s_d.ack = !s_q.prov_v;
        if (!s_q.prov_v && wb_sel_i == `TXD_SEL_ALL)
        begin
          s_d.prov_v = 1'b1;
          s_d.prov_act = wb_dat_i[`TXD_PROV_ACT_BIT];
          s_d.prov_chan = wb_dat_i[`TXD_REF_CHAN_LSB +: 10];
        end
      end
      else if (!wb_we_i && wb_adr_i == `TXD_REG_STATUS)
      begin
        s_d.ack = 1'b1;
        s_d.rdat = {24'h00_0000, 1'b0, s_q.tk, s_q.ref_v, s_q.prov_v,
                    s_q.req_v, s_q.desc_v};
        s_d.rdat[31:30] = s_q.st;
      end
      else if (!wb_we_i && wb_adr_i == `TXD_REG_LINKS)
      begin
        s_d.ack = 1'b1;
        s_d.rdat = {16'h0000, s_q.links};
      end
      else
      begin
        s_d.ack = 1'b1;
      end
    end
    // downstream slots
    if (req_valid && s_q.req_rdy)
    begin
      s_d.req_v = 1'b1;
      s_d.req = req_in;
    end
    if (desc_valid && s_q.desc_rdy)
    begin
      s_d.desc_v = 1'b1;
      s_d.desc = desc_in;
    end
    case (s_q.st)
      txdma_pkg::S_INIT:
      begin
        wr_hi_en = 1'b1;
        wr_lo_en = 1'b1;
        hi_w = '0;
        lo_w = '0;
        s_d.cnt = s_q.cnt + 10'h001;
        if (s_q.cnt == `TXD_LAST_CHAN)
        begin
          s_d.st = txdma_pkg::S_IDLE;
        end
      end
      txdma_pkg::S_IDLE:
      begin
        s_d.tk = pick;
        if (pick != txdma_pkg::T_NONE)
        begin
          s_d.st = txdma_pkg::S_READ;
        end
        if (pick == txdma_pkg::T_EXP || pick == txdma_pkg::T_NRM)
        begin
          s_d.chan = s_q.req.chan;
        end
        else if (pick == txdma_pkg::T_LINK)
        begin
          s_d.chan = s_q.rref.chan;
        end
        else if (pick == txdma_pkg::T_DESC)
        begin
          s_d.chan = s_q.desc.chan;
        end
        else if (pick == txdma_pkg::T_PROV)
        begin
          s_d.chan = s_q.prov_chan;
        end
      end
      txdma_pkg::S_READ:
      begin
        s_d.st = txdma_pkg::S_EXEC;
      end
      txdma_pkg::S_EXEC:
      begin
        s_d.st = txdma_pkg::S_IDLE;
        case (s_q.tk)
          txdma_pkg::T_LINK:
          begin
            s_d.ref_v = 1'b0;
            p = s_q.rref.pri;
            e = p ? hi : lo;
            if (!e.act)
            begin
              s_d.free_v = 1'b1;
              s_d.free = s_q.rref;
              s_d.free_u = e.u;
              e.u = 1'b0; // RULE9
            end
            else if (!e.nonempty)
            begin
              e.nonempty = 1'b1; // RULE4
              e.cur_ptr = s_q.rref.ptr; // RULE5
              e.last_ptr = s_q.rref.ptr; // RULE12
              e.v = 1'b0;
              e.bytes = 16'h0000;
              s_d.fetch_v = 1'b1;
              s_d.fetch = s_q.rref;
            end
            else
            begin
              // chain joined behind the head of the last chain
              s_d.link_v = 1'b1; // RULE13 RULE14
              s_d.link_from = e.last_ptr;
              s_d.link_to = s_q.rref;
              if (!e.v)
              begin
                e.next_ptr = s_q.rref.ptr; // RULE12
              end
              e.last_ptr = s_q.rref.ptr; // RULE12
              e.v = 1'b1; // RULE11 RULE14
              s_d.links = s_q.links + 16'h0001;
            end
          end
          txdma_pkg::T_DESC:
          begin
            s_d.desc_v = 1'b0;
            p = s_q.desc.pri;
            e = p ? hi : lo;
            e.abrt = s_q.desc.abrt; // RULE2
            e.irq_on_complete_copy = s_q.desc.irq_on_complete_copy; // RULE2
            e.m = s_q.desc.m; // RULE2
            e.ce = s_q.desc.ce; // RULE2
            e.bytes = s_q.desc.bytes; // RULE6
            e.host_ptr = s_q.desc.host_ptr; // RULE7
            e.addr = s_q.desc.addr; // RULE8
            if (s_q.desc.malformed)
            begin
              e.null_abort_pending = 1'b1; // RULE1
              e.bytes = 16'h0000;
            end
          end
          txdma_pkg::T_EXP, txdma_pkg::T_NRM:
          begin
            s_d.req_v = 1'b0;
            if (hi.packet_in_progress)
            begin
              p = 1'b1; // RULE10
            end
            else if (lo.packet_in_progress)
            begin
              p = 1'b0; // RULE10
            end
            else
            begin
              p = hi.nonempty; // RULE16
            end
            e = p ? hi : lo;
            if (s_q.req.underflow)
            begin
              e.u = 1'b1; // RULE9
            end
            s_d.ans_v = 1'b1;
            s_d.ans = '0;
            s_d.ans.chan = s_q.chan;
            s_d.ans.pri = p;
            s_d.ans.none = 1'b1;
            if (!e.act || !e.nonempty)
            begin
              s_d.ans.none = 1'b1; // RULE3 RULE4
            end
            else if (e.null_abort_pending)
            begin
              s_d.ans.none = 1'b0;
              s_d.ans.null_abort = 1'b1; // RULE1
              s_d.free_v = 1'b1;
              s_d.free = {s_q.chan, p, e.cur_ptr};
              s_d.free_u = e.u;
              e.null_abort_pending = 1'b0;
              e.packet_in_progress = 1'b0;
              e = advance(e);
              s_d.fetch_v = e.nonempty;
              s_d.fetch = {s_q.chan, p, e.cur_ptr};
            end
            else if (e.bytes != 16'h0000)
            begin
              s_d.ans.none = 1'b0;
              s_d.ans.addr = e.addr;
              e.addr = e.addr + `TXD_ADDR_STEP; // RULE8
              e.bytes = dec_bytes(e.bytes); // RULE6
              e.packet_in_progress = 1'b1; // RULE10
              if (e.bytes == 16'h0000)
              begin
                s_d.ans.last = 1'b1;
                s_d.free_v = 1'b1; // RULE9
                s_d.free = {s_q.chan, p, e.cur_ptr};
                s_d.free_u = e.u;
                e.packet_in_progress = e.m; // RULE10
                e = advance(e); // RULE21
                s_d.fetch_v = e.nonempty;
                s_d.fetch = {s_q.chan, p, e.cur_ptr};
              end
            end
          end
          txdma_pkg::T_PROV:
          begin
            s_d.prov_v = 1'b0;
            hi_w.act = s_q.prov_act; // RULE3
            lo_w.act = s_q.prov_act; // RULE3
            if (!s_q.prov_act)
            begin
              hi_w.nonempty = 1'b0;
              lo_w.nonempty = 1'b0;
              hi_w.v = 1'b0;
              lo_w.v = 1'b0;
              hi_w.packet_in_progress = 1'b0;
              lo_w.packet_in_progress = 1'b0;
              hi_w.null_abort_pending = 1'b0;
              lo_w.null_abort_pending = 1'b0;
            end
            wr_hi_en = 1'b1;
            wr_lo_en = 1'b1;
          end
          default:
          begin
            s_d.st = txdma_pkg::S_IDLE;
          end
        endcase
        if (s_q.tk != txdma_pkg::T_PROV && s_q.tk != txdma_pkg::T_NONE)
        begin
          wr_hi_en = p;
          wr_lo_en = !p;
          hi_w = e;
          lo_w = e;
        end
      end
      default:
      begin
        s_d.st = txdma_pkg::S_INIT;
      end
    endcase
    s_d.req_rdy = !s_d.req_v;
    s_d.desc_rdy = !s_d.desc_v;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign req_ready = s_q.req_rdy;
  assign desc_ready = s_q.desc_rdy;
  assign ans_valid = s_q.ans_v;
  assign ans_out = s_q.ans;
  assign free_valid = s_q.free_v;
  assign free_ref = s_q.free;
  assign free_uflow = s_q.free_u;
  assign link_valid = s_q.link_v;
  assign link_from = s_q.link_from;
  assign link_to = s_q.link_to;
  assign fetch_valid = s_q.fetch_v;
  assign fetch_ref = s_q.fetch;
endmodule

//--- testbench/list_manager_properties.sv
`timescale 1ns/1ps
module list_checker (
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset
  input wire logic req_valid, // request
  input txdma_pkg::req_t req_in, // request kind
  input wire logic req_ready, // slot free
  input wire logic ans_valid, // answer
  input txdma_pkg::ans_t ans_out, // answer data
  input wire logic free_valid, // release
  input txdma_pkg::ref_t free_ref, // released ref
  input wire logic link_valid // link pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic pend_q;
  logic open_q;
  logic pri_q;
  logic [9:0] ch_q;
  logic [9:0] pch_q;
  logic [31:0] adr_q;
  logic [9:0] up_q;
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pend_q <= 1'b0;
      open_q <= 1'b0;
      up_q <= 10'h000;
    end
    else
    begin
      // cycles since reset, saturating once the table sweep is over
      if (up_q != 10'h2a8)
        up_q <= up_q + 10'h001;
      if (req_valid && req_ready)
        pend_q <= 1'b1;
      else if (ans_valid)
        pend_q <= 1'b0;
      if (req_valid && req_ready)
        ch_q <= req_in.chan;
      if (ans_valid)
      begin
        open_q <= !(ans_out.none || ans_out.last || ans_out.null_abort);
        pch_q <= ans_out.chan;
        pri_q <= ans_out.pri;
        adr_q <= ans_out.addr;
      end
    end
  end
  a_null_abort_frees: assert property (
    ans_valid && ans_out.null_abort |-> !ans_out.none && free_valid
    && free_ref.chan == ans_out.chan)
    else $error("null abort without release");
  a_last_releases: assert property (
    ans_valid && ans_out.last |-> free_valid
    && free_ref.chan == ans_out.chan && free_ref.pri == ans_out.pri)
    else $error("last dword without release");
  a_addr_step_four: assert property (
    ans_valid && open_q && ans_out.chan == pch_q && ans_out.pri == pri_q
    && !ans_out.none && !ans_out.null_abort
    |-> ans_out.addr == adr_q + 32'h0000_0004)
    else $error("address did not step by one dword");
  a_exp_served_fast: assert property (
    up_q == 10'h2a8 && req_valid && req_ready && req_in.exp
    |-> ##[3:40] ans_valid)
    else $error("expedited request not served in time");
  a_nrm_answered: assert property (
    req_valid && req_ready && !req_in.exp |-> ##[3:1000] ans_valid)
    else $error("ordinary request never served");
  a_ans_own_chan: assert property (
    ans_valid |-> pend_q && ans_out.chan == ch_q)
    else $error("answer without matching request");
  a_ans_single: assert property (
    ans_valid |=> !ans_valid)
    else $error("answer longer than one cycle");
  a_slot_taken: assert property (
    req_valid && req_ready |=> !req_ready)
    else $error("request slot still free after take");
  a_none_no_data: assert property (
    ans_valid && ans_out.none |-> !ans_out.last && !ans_out.null_abort)
    else $error("empty answer carries data flags");
  c_last: cover property (ans_valid && ans_out.last);
  c_null: cover property (ans_valid && ans_out.null_abort);
  c_link: cover property (link_valid);
endmodule
bind tx_dma_list_manager list_checker u_chk (.clk_sys(clk_sys),
  .resetn(resetn), .req_valid(req_valid), .req_in(req_in),
  .req_ready(req_ready), .ans_valid(ans_valid), .ans_out(ans_out),
  .free_valid(free_valid), .free_ref(free_ref), .link_valid(link_valid));

//--- testbench/host_desc_model.sv
`timescale 1ns/1ps
module host_desc_model (
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset
  input wire logic fetch_valid, // fetch pulse
  input txdma_pkg::ref_t fetch_ref, // fetch target
  input wire logic desc_ready, // slot free
  output logic desc_valid, // descriptor offered
  output txdma_pkg::desc_t desc_in // descriptor fields
);
  txdma_pkg::ref_t q[$];
  txdma_pkg::ref_t r;
  int wt;
  logic slow;
  // replies alternate fast and slow; idle data toggles
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      desc_valid <= 1'b0;
      desc_in <= '0;
      q.delete();
      wt <= 0;
      slow <= 1'b0;
    end
    else
    begin
      if (fetch_valid)
        q.push_back(fetch_ref);
      if (desc_valid)
      begin
        if (desc_ready)
        begin
          desc_valid <= 1'b0;
          desc_in <= ~desc_in;
        end
      end
      else if (q.size() == 0 || wt < (slow ? 5 : 1))
      begin
        wt <= (q.size() == 0) ? 0 : wt + 1;
        desc_in <= ~desc_in;
      end
      else
      begin
        r = q.pop_front();
        desc_valid <= 1'b1;
        // ptr bit 14 marks a bad one; bit 13 opens a two-deep chain
        desc_in <= '{r.chan, r.pri, r.ptr[14], 1'b0, 1'b0,
          r.ptr[13] & ~r.ptr[0], ~r.ptr[13] | r.ptr[0],
          16'h0008, r.ptr + 15'h0001, {13'h0000, r.ptr, 4'h0}};
        wt <= 0;
        slow <= ~slow;
      end
    end
  end
endmodule

//--- testbench/tx_dma_list_manager_tb.sv
`timescale 1ns/1ps
module tx_dma_list_manager_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'hf;
  logic req_valid = 1'b0;
  txdma_pkg::req_t req_in = '0;
  logic wb_ack_o, req_ready, desc_valid, desc_ready, ans_valid;
  logic free_valid, free_uflow, link_valid, fetch_valid, fv, fu;
  logic [31:0] wb_dat_o, rd;
  logic [14:0] link_from, lf;
  txdma_pkg::desc_t desc_in;
  txdma_pkg::ans_t ans_out, a;
  txdma_pkg::ref_t free_ref, link_to, fetch_ref, fr, lt;
  int errors = 0;
  int n_tests = 0;
  int nf = 0;
  int nd = 0;
  int nl = 0;
  always #4 clk_sys = ~clk_sys;
  tx_dma_list_manager DUT (.clk_sys(clk_sys), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .req_valid(req_valid),
    .req_in(req_in), .req_ready(req_ready), .desc_valid(desc_valid),
    .desc_in(desc_in), .desc_ready(desc_ready), .ans_valid(ans_valid),
    .ans_out(ans_out), .free_valid(free_valid), .free_ref(free_ref),
    .free_uflow(free_uflow), .link_valid(link_valid),
    .link_from(link_from), .link_to(link_to),
    .fetch_valid(fetch_valid), .fetch_ref(fetch_ref));
  host_desc_model u_host (.clk_sys(clk_sys), .resetn(resetn),
    .fetch_valid(fetch_valid), .fetch_ref(fetch_ref),
    .desc_ready(desc_ready), .desc_valid(desc_valid), .desc_in(desc_in));
  always @(posedge clk_sys)
  begin
    if (fetch_valid === 1'b1)
      nf++;
    if (desc_valid === 1'b1 && desc_ready === 1'b1)
      nd++;
    if (link_valid === 1'b1)
    begin
      nl++;
      lf = link_from;
      lt = link_to;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function logic [31:0] ea(input logic [14:0] p);
    return {13'h0000, p, 4'h0};
  endfunction
  task wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 3000);
    rd = wb_dat_o;
    chk(wb_ack_o, 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task post(input logic [9:0] ch, input logic pr, input logic [14:0] p);
    wb(1'b1, 8'h00, {6'h00, ch, pr, p});
  endtask
  task settle;
    for (int n = 0; n < 100; n++)
    begin
      wb(1'b0, 8'h08, 32'h0000_0000);
      if (rd[3:0] == 4'h0 && nf == nd && desc_valid !== 1'b1)
        break;
    end
  endtask
  task rq(input logic [9:0] ch, input logic ex, input logic uf);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 400)
    begin
      @(posedge clk_sys);
      n++;
    end
    req_valid <= 1'b1;
    req_in <= {ch, ex, uf};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (req_ready !== 1'b1 && n < 800);
    req_valid <= 1'b0;
    req_in <= ~{ch, ex, uf};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ans_valid !== 1'b1 && n < 2000);
    chk(ans_valid, 1'b1);
    a = ans_out;
    fv = free_valid;
    fr = free_ref;
    fu = free_uflow;
  endtask
  task pk(input logic [14:0] p, input logic pr, input logic uf,
    input logic ex);
    settle;
    rq(10'h005, ex, uf);
    chk(a.pri, pr);
    chk(a.addr, ea(p));
    chk({a.none, a.last}, 2'b00);
    rq(10'h005, 1'b0, 1'b0);
    chk(a.addr, ea(p) + 32'h0000_0004);
    chk(a.last, 1'b1);
    chk({fv, fr.ptr}, {1'b1, p});
    chk(fu, uf);
  endtask
  initial
  begin
    logic [15:0] c;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 400; i++)
    begin
      wb(1'b0, 8'h08, 32'h0000_0000);
      if (rd[31:30] !== 2'b00)
        break;
    end
    wb(1'b1, 8'h10, 32'hffff_ffff);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    rq(10'h007, 1'b0, 1'b0);
    chk(a.none, 1'b1);
    wb(1'b1, 8'h04, 32'h0005_0001);
    rq(10'h005, 1'b0, 1'b0);
    chk(a.none, 1'b1);
    post(10'h005, 1'b1, 15'h0020);
    pk(15'h0020, 1'b1, 1'b1, 1'b0);
    rq(10'h005, 1'b0, 1'b0);
    chk(a.none, 1'b1);
    post(10'h005, 1'b0, 15'h0030);
    post(10'h005, 1'b1, 15'h0040);
    pk(15'h0040, 1'b1, 1'b0, 1'b1);
    pk(15'h0030, 1'b0, 1'b0, 1'b0);
    wb(1'b0, 8'h0c, 32'h0000_0000);
    c = rd[15:0];
    post(10'h005, 1'b1, 15'h0050);
    post(10'h005, 1'b1, 15'h0060);
    settle;
    chk(nl, 32'd1);
    chk(lf, 15'h0050);
    chk(lt, {10'h005, 1'b1, 15'h0060});
    wb(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd[15:0], c + 16'h0001);
    pk(15'h0050, 1'b1, 1'b0, 1'b0);
    pk(15'h0060, 1'b1, 1'b0, 1'b0);
    post(10'h005, 1'b1, 15'h2080);
    pk(15'h2080, 1'b1, 1'b0, 1'b0);
    pk(15'h2081, 1'b1, 1'b0, 1'b0);
    post(10'h005, 1'b1, 15'h4070);
    settle;
    rq(10'h005, 1'b0, 1'b0);
    chk({a.null_abort, fr.ptr}, {1'b1, 15'h4070});
    rq(10'h005, 1'b0, 1'b0);
    chk(a.none, 1'b1);
    wb(1'b1, 8'h04, 32'h0005_0000);
    rq(10'h005, 1'b0, 1'b0);
    chk(a.none, 1'b1);
    test_done;
  end
  initial
  begin
    #400000;
    errors++;
    $display("[FAIL] %0t timeout", $time);
    test_done;
  end
endmodule
